// ### logic/arac_top.sv
// Arithmetic accelerator: divide, multiply, shift, normalize, 40-bit accumulator
`timescale 1ns/100ps
module arac_top
   import arac_pkg::*;
#(
   parameter int ACC_W = 40
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [DATA_W-1:0] writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [DATA_W-1:0] readdata,
   output logic                   waitrequest
);

   arac_state_t      state;
   logic             ack_q;
   logic [2:0]       a_cnt;
   logic [1:0]       b_cnt;
   logic             mul_first;
   logic             div_long;
   logic [1:0]       kind;
   logic [31:0]      op_a;
   logic [15:0]      op_b;
   logic [31:0]      res_a;
   logic [15:0]      res_b;
   logic             res_ovf;
   logic             res_carry;
   logic [4:0]       res_count;
   logic [2:0]       rd_a_left;
   logic [1:0]       rd_b_left;
   logic [5:0]       busy_cnt;
   logic [ACC_W-1:0] acc;
   logic [2:0]       acc_rd;
   logic             dir;
   logic             circ;
   logic             cen;
   logic [4:0]       scount;
   logic             ovf;
   logic             scarry;

   // Bus decode
   logic [7:0]  idx;
   logic [7:0]  wd8;
   logic        accept;
   logic        wr_en;
   logic        wr_a;
   logic        wr_b;
   logic        wr_ctl;
   logic        wr_st;
   logic        wr_acc;
   logic        rd_a;
   logic        rd_b;
   logic        rd_acc;
   logic        busy;
   logic        busy_clear;
   logic        clear_ops;
   logic        done;
   logic        acc_ok;
   logic [7:0]  rd_byte;

   assign idx         = address[ADDR_W-1:IDX_LSB];
   assign wd8         = writedata[7:0];
   assign waitrequest = (read | write) & ~ack_q;
   assign accept      = (read | write) & ack_q;
   assign wr_en       = accept & write & byteenable[0];
   assign wr_a        = wr_en & (idx == IDX_OPA);
   assign wr_b        = wr_en & (idx == IDX_OPB);
   assign wr_ctl      = wr_en & (idx == IDX_SHIFT_CTL);
   assign wr_st       = wr_en & (idx == IDX_STATUS);
   assign wr_acc      = wr_en & (idx == IDX_ACC);
   assign rd_a        = accept & read & (idx == IDX_OPA);
   assign rd_b        = accept & read & (idx == IDX_OPB);
   assign rd_acc      = accept & read & (idx == IDX_ACC);
   assign busy        = (state == ARAC_BUSY) | (state == ARAC_CORRUPT);
   // Only a set busy flag can be cleared, so a status write made while
   // loading operands does not throw the loaded bytes away
   assign busy_clear  = wr_st & ~wd8[ST_BUSY_BIT] & busy;
   assign clear_ops   = wr_st & wd8[ST_CLR_BIT];
   assign done        = (state == ARAC_BUSY) & (busy_cnt == 6'h01) & ~busy_clear;
   assign acc_ok      = (state == ARAC_IDLE) | (state == ARAC_RESULT);

   // Operation datapath, evaluated on the byte that completes the operands
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic [31:0] div_q;
   logic [15:0] div_r;
   logic [31:0] prod;
   logic [32:0] sh_res;
   logic [36:0] nm_res;

   assign dividend = div_long ? op_a : {16'h0000, op_a[15:0]};
   assign divisor  = {wd8, op_b[7:0]};
   assign div_q    = (divisor == 16'h0000) ? 32'hFFFF_FFFF : dividend / {16'h0000, divisor};
   assign div_r    = (divisor == 16'h0000) ? dividend[15:0] : 16'(dividend % {16'h0000, divisor});
   assign prod     = {16'h0000, op_b} * {16'h0000, wd8, op_a[7:0]};

   function automatic logic [32:0] shift_fn(input logic [31:0] v, input logic c,
                                            input logic left, input logic wrap,
                                            input logic use_c, input logic [4:0] n);
      logic [31:0] val;
      logic        cy;
      logic        out;
      logic        fill;
      val = v;
      cy  = c;
      for (int i = 0; i < 31; i++) begin
         if (5'(i) < n) begin
            out  = left ? val[31] : val[0];
            // With carry and wrap enabled the carry is a 33rd bit of the ring
            fill = use_c ? (wrap ? cy : 1'b0) : (wrap ? out : 1'b0);
            if (use_c) begin
               cy = out;
            end
            val = left ? {val[30:0], fill} : {fill, val[31:1]};
         end
      end
      return {cy, val};
   endfunction : shift_fn

   function automatic logic [36:0] norm_fn(input logic [31:0] v);
      logic [31:0] val;
      logic [4:0]  n;
      val = v;
      n   = 5'h00;
      for (int i = 0; i < 31; i++) begin
         if (!val[31]) begin
            val = {val[30:0], 1'b0};
            n   = n + 5'h01;
         end
      end
      return {n, val};
   endfunction : norm_fn

   assign sh_res = shift_fn(op_a, scarry, wd8[CTL_DIR_BIT], wd8[CTL_CIRC_BIT],
                            wd8[CTL_CEN_BIT], wd8[CTL_CNT_MSB:0]);
   assign nm_res = norm_fn(op_a);

   // Read mux
   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         IDX_SHIFT_CTL: rd_byte = {dir, circ, cen, scount};
         IDX_STATUS:    rd_byte = {busy, ovf, scarry, 5'h00};
         IDX_OPA:       rd_byte = (state == ARAC_RESULT && rd_a_left != 3'h0) ?
                                  res_a[8*(rd_a_left-3'h1) +: 8] : 8'h00;
         IDX_OPB:       rd_byte = (state == ARAC_RESULT && rd_b_left != 2'h0) ?
                                  res_b[8*(rd_b_left-2'h1) +: 8] : 8'h00;
         IDX_ACC:       rd_byte = acc[8*acc_rd +: 8];
         default:       rd_byte = 8'h00;
      endcase
   end

   // Bus handshake: one wait state, data captured while waitrequest is high
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q    <= 1'b0;
         readdata <= 32'h0000_0000;
      end else begin
         ack_q <= (read | write) & ~ack_q;
         if (read && !ack_q) begin
            readdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Operand sequencer; status, shift control and accumulator accesses also reach it
   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= ARAC_IDLE;
         a_cnt     <= 3'h0;
         b_cnt     <= 2'h0;
         mul_first <= 1'b0;
         div_long  <= 1'b0;
         kind      <= KIND_DIV;
         op_a      <= 32'h0000_0000;
         op_b      <= 16'h0000;
         res_a     <= 32'h0000_0000;
         res_b     <= 16'h0000;
         res_ovf   <= 1'b0;
         res_carry <= 1'b0;
         res_count <= 5'h00;
         rd_a_left <= 3'h0;
         rd_b_left <= 2'h0;
         busy_cnt  <= 6'h00;
      end else if (busy_clear) begin
         state <= ARAC_IDLE;
         a_cnt <= 3'h0;
         b_cnt <= 2'h0;
      end else begin
         case (state)
            ARAC_IDLE: begin
               a_cnt <= 3'h0;
               b_cnt <= 2'h0;
               if (wr_a) begin
                  op_a[7:0] <= wd8;
                  a_cnt     <= 3'h1;
                  mul_first <= 1'b0;
                  state     <= ARAC_COLLECT;
               end else if (wr_b) begin
                  op_b[7:0] <= wd8;
                  b_cnt     <= 2'h1;
                  mul_first <= 1'b1;
                  state     <= ARAC_COLLECT;
               end else if (rd_a || rd_b) begin
                  state <= ARAC_CORRUPT;
               end
            end
            ARAC_COLLECT: begin
               if (wr_a) begin
                  if (mul_first && b_cnt == B_BYTES && a_cnt == 3'h0) begin
                     op_a[7:0] <= wd8;
                     a_cnt     <= 3'h1;
                  end else if (mul_first && b_cnt == B_BYTES && a_cnt == 3'h1) begin
                     res_a    <= prod;
                     res_ovf  <= prod > RESULT_LIMIT;
                     kind     <= KIND_MUL;
                     busy_cnt <= MUL_CNT;
                     state    <= ARAC_BUSY;
                  end else if (!mul_first && b_cnt == 2'h0 && a_cnt < A_BYTES_LONG) begin
                     op_a[8*a_cnt +: 8] <= wd8;
                     a_cnt              <= a_cnt + 3'h1;
                     div_long           <= (a_cnt == 3'h3);
                  end else begin
                     state <= ARAC_CORRUPT;
                  end
               end else if (wr_b) begin
                  if (mul_first && b_cnt == 2'h1 && a_cnt == 3'h0) begin
                     op_b[15:8] <= wd8;
                     b_cnt      <= B_BYTES;
                  end else if (!mul_first && (a_cnt == A_BYTES_SHORT ||
                               a_cnt == A_BYTES_LONG) && b_cnt == 2'h0) begin
                     op_b[7:0] <= wd8;
                     b_cnt     <= 2'h1;
                  end else if (!mul_first && b_cnt == 2'h1) begin
                     res_a    <= div_q;
                     res_b    <= div_r;
                     res_ovf  <= (divisor == 16'h0000) | (div_q > RESULT_LIMIT);
                     kind     <= KIND_DIV;
                     busy_cnt <= DIV_CNT;
                     state    <= ARAC_BUSY;
                  end else begin
                     state <= ARAC_CORRUPT;
                  end
               end else if (wr_ctl && !mul_first && a_cnt == A_BYTES_LONG && b_cnt == 2'h0) begin
                  if (wd8[CTL_CNT_MSB:0] == 5'h00) begin
                     res_a     <= nm_res[31:0];
                     res_count <= nm_res[36:32];
                     kind      <= KIND_NORM;
                  end else begin
                     res_a     <= sh_res[31:0];
                     res_carry <= sh_res[32];
                     kind      <= KIND_SHIFT;
                  end
                  res_ovf  <= 1'b0;
                  busy_cnt <= DIV_CNT;
                  state    <= ARAC_BUSY;
               end else if (rd_a || rd_b || wr_acc || rd_acc) begin
                  state <= ARAC_CORRUPT;
               end
            end
            ARAC_BUSY: begin
               busy_cnt <= busy_cnt - 6'h01;
               if (wr_a || wr_b || rd_a || rd_b || wr_acc || rd_acc) begin
                  state <= ARAC_CORRUPT;
               end else if (done) begin
                  state     <= ARAC_RESULT;
                  a_cnt     <= 3'h0;
                  b_cnt     <= 2'h0;
                  rd_a_left <= (kind == KIND_DIV && !div_long) ? A_BYTES_SHORT : A_BYTES_LONG;
                  rd_b_left <= (kind == KIND_DIV) ? B_BYTES : 2'h0;
               end
            end
            ARAC_RESULT: begin
               if (rd_a) begin
                  if (rd_a_left == 3'h0) begin
                     state <= ARAC_CORRUPT;
                  end else begin
                     rd_a_left <= rd_a_left - 3'h1;
                     if (rd_a_left == 3'h1 && rd_b_left == 2'h0) begin
                        state <= ARAC_IDLE;
                     end
                  end
               end else if (rd_b) begin
                  if (rd_b_left == 2'h0 || rd_a_left != 3'h0) begin
                     state <= ARAC_CORRUPT;
                  end else begin
                     rd_b_left <= rd_b_left - 2'h1;
                     if (rd_b_left == 2'h1) begin
                        state <= ARAC_IDLE;
                     end
                  end
               end else if (wr_a || wr_b) begin
                  state <= ARAC_CORRUPT;
               end
            end
            ARAC_CORRUPT: begin
               // Held until software clears the busy flag
               state <= ARAC_CORRUPT;
            end
            default: begin
               state <= ARAC_IDLE;
            end
         endcase
         if (clear_ops) begin
            op_a  <= 32'h0000_0000;
            op_b  <= 16'h0000;
            res_a <= 32'h0000_0000;
            res_b <= 16'h0000;
         end
      end
   end

   // Accumulator: software load and readout, automatic summing of divide and multiply results
   always_ff @(posedge clk) begin
      if (rst) begin
         acc    <= '0;
         acc_rd <= ACC_TOP_BYTE;
      end else if (clear_ops) begin
         acc    <= '0;
         acc_rd <= ACC_TOP_BYTE;
      end else if (done && (kind == KIND_DIV || kind == KIND_MUL)) begin
         acc    <= acc + {{(ACC_W-32){1'b0}}, res_a};
         acc_rd <= ACC_TOP_BYTE;
      end else if (acc_ok && wr_acc) begin
         acc    <= {wd8, acc[ACC_W-1:8]};
         acc_rd <= ACC_TOP_BYTE;
      end else if (acc_ok && rd_acc) begin
         acc_rd <= (acc_rd == 3'h0) ? ACC_TOP_BYTE : acc_rd - 3'h1;
      end
   end

   // Shift control fields; completion results win over a same-cycle write
   always_ff @(posedge clk) begin
      if (rst) begin
         dir    <= 1'b0;
         circ   <= 1'b0;
         cen    <= 1'b0;
         scount <= 5'h00;
      end else begin
         if (wr_ctl) begin
            dir    <= wd8[CTL_DIR_BIT];
            circ   <= wd8[CTL_CIRC_BIT];
            cen    <= wd8[CTL_CEN_BIT];
            scount <= wd8[CTL_CNT_MSB:0];
         end
         if (done && kind == KIND_NORM) begin
            scount <= res_count;
         end
      end
   end

   // Status flags; hardware set wins over a software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         ovf    <= 1'b0;
         scarry <= 1'b0;
      end else begin
         if (wr_st) begin
            ovf    <= wd8[ST_OVF_BIT];
            scarry <= wd8[ST_CARRY_BIT];
         end
         if (done && res_ovf) begin
            ovf <= 1'b1;
         end
         if (done && kind == KIND_SHIFT && cen) begin
            scarry <= res_carry;
         end
      end
   end
endmodule : arac_top

// ### logic/arac_pkg.sv
// Constants, register map and types for the arithmetic accelerator
package arac_pkg;
   // Avalon-MM geometry: byte address, one register per aligned word
   localparam int ADDR_W         = 10;
   localparam int DATA_W         = 32;
   localparam int IDX_LSB        = 2;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SHIFT_CTL = 8'hD1;
   localparam logic [7:0] IDX_STATUS    = 8'hD2;
   localparam logic [7:0] IDX_OPA       = 8'hD3;
   localparam logic [7:0] IDX_OPB       = 8'hD4;
   localparam logic [7:0] IDX_ACC       = 8'hD5;
   // shift_control fields
   localparam int CTL_DIR_BIT    = 7;
   localparam int CTL_CIRC_BIT   = 6;
   localparam int CTL_CEN_BIT    = 5;
   localparam int CTL_CNT_MSB    = 4;
   // accel_status_control fields
   localparam int ST_BUSY_BIT    = 7;
   localparam int ST_OVF_BIT     = 6;
   localparam int ST_CARRY_BIT   = 5;
   localparam int ST_CLR_BIT     = 4;
   // Byte counts of the operand sequences, accumulator top byte index and result limit
   localparam logic [2:0] A_BYTES_LONG  = 3'h4;
   localparam logic [2:0] A_BYTES_SHORT = 3'h2;
   localparam logic [1:0] B_BYTES       = 2'h2;
   localparam logic [2:0] ACC_TOP_BYTE  = 3'h4;
   localparam logic [31:0] RESULT_LIMIT = 32'h0000_FFFF;
   // Timing: core clock and machine cycle, longest times rounded down
   localparam int CLK_PERIOD_NS    = 100;
   localparam int MACHINE_CYCLE_NS = 400;
   localparam int DIV_MACHINE_CYC  = 9;
   localparam int MUL_MACHINE_CYC  = 6;
   localparam int DIV_CLKS = (DIV_MACHINE_CYC * MACHINE_CYCLE_NS) / CLK_PERIOD_NS;
   localparam int MUL_CLKS = (MUL_MACHINE_CYC * MACHINE_CYCLE_NS) / CLK_PERIOD_NS;
   localparam logic [5:0] DIV_CNT = 6'(DIV_CLKS);
   localparam logic [5:0] MUL_CNT = 6'(MUL_CLKS);
   // Operation kinds
   localparam logic [1:0] KIND_DIV   = 2'h0;
   localparam logic [1:0] KIND_MUL   = 2'h1;
   localparam logic [1:0] KIND_SHIFT = 2'h2;
   localparam logic [1:0] KIND_NORM  = 2'h3;
   // Operand sequencer states
   typedef enum logic [4:0] {
      ARAC_IDLE    = 5'b00001,
      ARAC_COLLECT = 5'b00010,
      ARAC_BUSY    = 5'b00100,
      ARAC_RESULT  = 5'b01000,
      ARAC_CORRUPT = 5'b10000
   } arac_state_t;
endpackage : arac_pkg

// ### tb/arac_top_chk.sv
// Port checker for the arithmetic accelerator
`timescale 1ns/100ps
module arac_top_chk
   import arac_pkg::*;
#(
   parameter int ACC_W = 40
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [3:0]        byteenable,
   input wire logic [DATA_W-1:0] readdata,
   input wire logic              waitrequest
);
   logic       rq;
   logic       tk;
   logic       clr;
   logic       zed;
   logic [7:0] ix;
   assign rq  = read | write;
   assign tk  = rq & ~waitrequest;
   assign ix  = address[9:2];
   assign clr = tk & write & byteenable[0] & (ix == IDX_STATUS) & writedata[ST_CLR_BIT];
   // Accumulator known to be zero; any operand or accumulator write ends that
   always_ff @(posedge clk) begin
      if (rst) zed <= 1'b0;
      else if (clr) zed <= 1'b1;
      else if (tk && write && ix inside {IDX_OPA, IDX_OPB, IDX_ACC}) zed <= 1'b0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_wait_first; rq && !$past(rq && waitrequest) |-> waitrequest; endproperty
   a_wait_first: assert property (p_wait_first) else $error("No wait state");
   property p_wait_one; rq && waitrequest |=> !waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("Access not answered");
   property p_idle; !rq |-> !waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("Wait without request");
   property p_stand; !(read && waitrequest) |=> $stable(readdata); endproperty
   a_stand: assert property (p_stand) else $error("Read data moved");
   property p_upper; tk && read |-> readdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("Upper read bits set");
   property p_unmap; tk && read && !(ix inside {[IDX_SHIFT_CTL:IDX_ACC]}) |-> readdata == 0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("Unmapped read not zero");
   property p_stat; tk && read && ix == IDX_STATUS |-> readdata[4:0] == 5'h0; endproperty
   a_stat: assert property (p_stat) else $error("Status low bits set");
   property p_clear; tk && read && ix == IDX_ACC && zed |-> readdata[7:0] == 8'h0; endproperty
   a_clear: assert property (p_clear) else $error("Accumulator not cleared");
endmodule : arac_top_chk

// ### tb/arac_top_tb.sv
// Self-checking bench for the arithmetic accelerator
`timescale 1ns/100ps
`define CHK(g, e, m) begin samples_checked++; if (((g) & (m)) !== ((e) & (m))) begin \
   error_cnt++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module arac_top_tb;
   import arac_pkg::*;
   localparam int     ACC_W = 40;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [DATA_W-1:0] writedata = '0;
   logic [3:0]        byteenable = 4'hF;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   int                error_cnt = 0;
   int                samples_checked = 0;
   int                seed = 6382;
   int                k;
   logic [15:0]       exp_q[$];
   logic [15:0]       note;
   logic [39:0]       acc_m = '0;
   logic [31:0]       va, res;
   logic [15:0]       vb, rem;
   logic [7:0]        ctl;
   logic [32:0]       sr;
   logic              cy;
   always #50 clk = ~clk;
   arac_top #(.ACC_W(ACC_W)) i_dut (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest));
   always @(posedge clk) begin
      if (read && waitrequest === 1'b0) begin
         note = exp_q.pop_front();
         `CHK(readdata[7:0], note[7:0], note[15:8])
      end
   end
   task automatic report_and_stop;
      $display("Comparisons %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   // One access; on a read d is the expected byte and m its mask
   task automatic bus(input logic [7:0] ix, input logic wr, input logic [7:0] d,
                      input logic [7:0] m);
      int n;
      n = 0;
      if (!wr) exp_q.push_back({m, d});
      @(posedge clk);
      address   <= {ix, 2'b00};
      write     <= wr;
      read      <= !wr;
      writedata <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      read  <= 1'b0;
      write <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : bus
   task automatic rd(input logic [7:0] ix, input logic [39:0] v, input int nb);
      for (int j = nb - 1; j >= 0; j--) bus(ix, 1'b0, v[8*j+:8], 8'hFF);
   endtask : rd
   task automatic wr(input logic [7:0] ix, input logic [39:0] v, input int nb);
      for (int j = 0; j < nb; j++) bus(ix, 1'b1, v[8*j+:8], 8'h00);
   endtask : wr
   // Carry rides along only when enabled; wrap picks carry or the bit that left
   function automatic logic [32:0] shm(input logic [31:0] v, input logic [7:0] c,
                                       input logic ci);
      logic o;
      logic b;
      for (int j = 0; j < int'(c[4:0]); j++) begin
         o  = c[7] ? v[31] : v[0];
         b  = c[6] ? (c[5] ? ci : o) : 1'b0;
         v  = c[7] ? {v[30:0], b} : {b, v[31:1]};
         ci = c[5] ? o : ci;
      end
      return {ci, v};
   endfunction : shm
   function automatic logic [4:0] lz(input logic [31:0] v);
      for (int j = 31; j >= 0; j--) if (v[j]) return 5'(31 - j);
      return 5'h1F;
   endfunction : lz
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      bus(IDX_STATUS, 1'b0, 8'h00, 8'hFF);
      bus(IDX_SHIFT_CTL, 1'b0, 8'h00, 8'hFF);
      bus(8'h10, 1'b1, 8'h5A, 8'h00);
      bus(8'h10, 1'b0, 8'h00, 8'hFF);
      bus(IDX_OPA, 1'b0, 8'h00, 8'h00);
      bus(IDX_STATUS, 1'b0, 8'h80, 8'h80);
      bus(IDX_STATUS, 1'b1, 8'h00, 8'h00);
      bus(IDX_STATUS, 1'b0, 8'h00, 8'h80);
      for (k = 0; k < 4; k++) begin
         va  = (k == 0) ? 32'hFFFF : $random(seed);
         vb  = (k == 0) ? 16'hFFFF : 16'($random(seed) >> (4 * k));
         res = va[15:0] * vb;
         cy  = res > RESULT_LIMIT;
         acc_m = acc_m + res;
         bus(IDX_STATUS, 1'b1, 8'h00, 8'h00);
         wr(IDX_OPB, vb, 2);
         bus(IDX_SHIFT_CTL, 1'b0, 8'h00, 8'hFF);
         wr(IDX_OPA, va[15:0], 2);
         bus(IDX_STATUS, 1'b0, 8'h80, 8'h80);
         repeat (MUL_CLKS) @(posedge clk);
         bus(IDX_STATUS, 1'b0, {1'b0, cy, 6'h0}, 8'hC0);
         rd(IDX_OPA, res, 4);
      end
      for (k = 0; k < 3; k++) begin
         va = $random(seed);
         vb = (k == 1) ? 16'h0 : 16'($random(seed)) | 16'h1;
         if (k == 2) va[31:16] = 16'h0;
         res = (vb == 16'h0) ? 32'hFFFF_FFFF : va / vb;
         rem = (vb == 16'h0) ? va[15:0] : 16'(va % vb);
         cy  = vb == 16'h0 || res > RESULT_LIMIT;
         acc_m = acc_m + res;
         bus(IDX_STATUS, 1'b1, 8'h00, 8'h00);
         wr(IDX_OPA, va, (k == 2) ? 2 : 4);
         wr(IDX_OPB, vb, 2);
         repeat (DIV_CLKS) @(posedge clk);
         bus(IDX_STATUS, 1'b0, {1'b0, cy, 6'h0}, 8'hC0);
         rd(IDX_OPA, res, (k == 2) ? 2 : 4);
         rd(IDX_OPB, rem, 2);
      end
      for (k = 0; k < 10; k++) begin
         va  = $random(seed);
         cy  = va[5];
         ctl = {k[2:0], 5'($random(seed)) | 5'h01};
         sr  = shm(va, ctl, cy);
         if (k >= 8) begin
            va  = (k == 9) ? 32'h0 : va >> va[4:0];
            ctl = {3'h0, lz(va)};
            sr  = {cy, va << lz(va)};
         end
         bus(IDX_STATUS, 1'b1, {2'h0, cy, 5'h0}, 8'h00);
         wr(IDX_OPA, va, 4);
         bus(IDX_SHIFT_CTL, 1'b1, (k >= 8) ? 8'h00 : ctl, 8'h00);
         repeat (DIV_CLKS) @(posedge clk);
         bus(IDX_STATUS, 1'b0, {2'h0, sr[32], 5'h0}, 8'hA0);
         rd(IDX_OPA, sr[31:0], 4);
         bus(IDX_SHIFT_CTL, 1'b0, ctl, 8'hFF);
      end
      rd(IDX_ACC, acc_m, 5);
      acc_m = {8'($random(seed)), 32'($random(seed))};
      wr(IDX_ACC, acc_m, 5);
      rd(IDX_ACC, acc_m, 5);
      bus(IDX_STATUS, 1'b1, 8'h10, 8'h00);
      rd(IDX_ACC, 40'h0, 5);
      report_and_stop();
   end
endmodule : arac_top_tb
bind arac_top arac_top_chk #(.ACC_W(ACC_W)) i_chk (.clk(clk), .rst(rst), .address(address),
   .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest));
